// >>> rtl/adcpm_pkg.sv
// adcpm_pkg: shared constants and types for the converter control link
// assumes a single 200 MHz system clock on both ends
package adcpm_pkg;
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned RES_BITS         = 12;
    localparam int unsigned WORD_BITS        = RES_BITS + 1;
    localparam int unsigned NAP_WAKE_NS      = 350;
    localparam int unsigned NAP_WAKE_CYC     = (NAP_WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SLEEP_WAKE_US    = 4000;
    localparam int unsigned SLEEP_WAKE_CYC   = SLEEP_WAKE_US * CLK_MHZ;
    localparam int unsigned CONVERSION_STROBE_CYC         = 14;
    localparam int unsigned SCLK_DIV         = 8;
    localparam logic [2:0]  PULSE_RST        = 3'h0;
    localparam logic [2:0]  PULSE_NAP        = 3'h2;
    localparam logic [2:0]  PULSE_SLEEP      = 3'h4;
    localparam logic [11:0] BIP_MAX_CODE     = 12'h7ff;

    typedef enum logic [1:0] {
        ADCPM_ACTIVE = 2'b00,
        ADCPM_NAP    = 2'b01,
        ADCPM_SLEEP  = 2'b11
    } adcpm_power_t;
endpackage

// >>> rtl/adcpm_if.sv
// adcpm_if: three-wire serial link between converter and host
// assumes both ends on clk_sys; the host drives sclk and strobe
`timescale 1ns/1ps
interface adcpm_if;
    logic sclk;
    logic conversion_strobe;
    logic dout;

    modport dev  (input sclk, input conversion_strobe, output dout);
    modport host (output sclk, output conversion_strobe, input dout);
endinterface

// >>> rtl/adcpm_device.sv
// adcpm_device: digital control of the serial converter
// assumes the comparator is strobed on clk_sys beside the trial word; vss and vref are async
// Operation
// - power-up lands in active, ready to convert
// - clock low, two strobes: light power-down
// - clock low, four strobes: deep sleep
// - light power-down keeps the reference powered
// - deep sleep powers off the reference too
// - serial clock rising edge wakes device
// - light power-down recovery takes 350 ns
// - deep sleep recovery about 4 ms
// - settled flag leads the output word
// - low reference pin forces flag low
// - negative supply below ground selects bipolar
// - unipolar result is natural binary
// - bipolar result is two's complement
// - host idles or isolates bus during conversion
// - strobe rise starts, clears register, no restart
// - bits resolved from msb down to lsb
// - data changes and is captured on rising clock
`timescale 1ns/1ps
module adcpm_device #(
    parameter int unsigned SLEEP_WAKE_CYC = adcpm_pkg::SLEEP_WAKE_CYC
) (
    input  wire logic clk_sys,        // system clock
    input  wire logic rst,            // sync reset, active high
    adcpm_if.dev      link,           // serial link
    input  wire logic comp_high,      // comparator: input above dac trial
    input  wire logic vss_below_gnd,  // negative supply below ground
    input  wire logic vref_low,       // reference pin held below nominal
    output logic      ref_powered,    // internal reference supply on
    output logic      core_powered,   // converter circuitry supply on
    output logic      bipolar,        // coding mode in use
    output logic [11:0] dac_trial     // trial word to the capacitive dac
);
    // the settle counter is 23 bits wide
    if (SLEEP_WAKE_CYC < 1 || SLEEP_WAKE_CYC > 32'h007fffff) begin : g_bad_wake
        $error("SLEEP_WAKE_CYC must fit the settle counter");
    end

    typedef enum logic [1:0] {
        ADCPM_IDLE  = 2'b00,
        ADCPM_CONVERSION_STROBE  = 2'b01,
        ADCPM_SHIFT = 2'b11
    } adcpm_seq_t;

    // ---------------------------------------------------------------
    // synchronisers
    // ---------------------------------------------------------------
    // the comparator answers the trial word within the cycle, so it is read directly:
    // two sync stages on it would judge each bit against an older trial
    logic [1:0] s_sclk, s_strb, s_vss, s_vref;
    always_ff @(posedge clk_sys) begin
        s_sclk <= {s_sclk[0], link.sclk};
        s_strb <= {s_strb[0], link.conversion_strobe};
        s_vss  <= {s_vss[0], vss_below_gnd};
        s_vref <= {s_vref[0], vref_low};
    end

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic                 sclk_d_reg, strb_d_reg;
    adcpm_pkg::adcpm_power_t pwr_reg, pwr_next;
    logic [2:0]           pulses_reg, pulses_next;
    logic [22:0]          settle_reg, settle_next;
    logic                 settled_reg, settled_next;
    adcpm_seq_t           seq_reg, seq_next;
    logic [3:0]           bit_reg, bit_next;
    logic [11:0]          sar_reg, sar_next;
    logic [12:0]          shreg_reg, shreg_next;
    logic                 dout_reg, dout_next;
    logic                 bip_reg, bip_next;

    wire sclk_rise = s_sclk[1] & ~sclk_d_reg;
    wire strb_rise = s_strb[1] & ~strb_d_reg;

    // ---------------------------------------------------------------
    // power mode and conversion sequencing
    // ---------------------------------------------------------------
    always_comb begin
        pwr_next     = pwr_reg;
        pulses_next  = pulses_reg;
        settle_next  = settle_reg;
        settled_next = settled_reg;
        seq_next     = seq_reg;
        bit_next     = bit_reg;
        sar_next     = sar_reg;
        shreg_next   = shreg_reg;
        dout_next    = dout_reg;
        bip_next     = s_vss[1];
        // counting down first lets a wake in the same cycle win the reload
        if (settle_reg != 23'h0) begin
            settle_next = settle_reg - 23'h1;
            if (settle_reg == 23'h1) settled_next = 1'b1;
        end
        if (sclk_rise) begin
            pulses_next = adcpm_pkg::PULSE_RST;
            if (pwr_reg != adcpm_pkg::ADCPM_ACTIVE) begin
                // nap keeps reference up, so only core wakes; sleep restarts settle
                settle_next = (pwr_reg == adcpm_pkg::ADCPM_SLEEP) ?
                    23'(SLEEP_WAKE_CYC) : 23'(adcpm_pkg::NAP_WAKE_CYC);
                if (pwr_reg == adcpm_pkg::ADCPM_SLEEP) settled_next = 1'b0;
                pwr_next = adcpm_pkg::ADCPM_ACTIVE;
            end
        end else if (strb_rise && !s_sclk[1]) begin
            // counted whatever the sequencer does: pulse one has already started a conversion
            if (pulses_reg != adcpm_pkg::PULSE_SLEEP) pulses_next = pulses_reg + 3'h1;
            if (pulses_reg + 3'h1 >= adcpm_pkg::PULSE_SLEEP)
                pwr_next = adcpm_pkg::ADCPM_SLEEP;
            else if (pulses_reg + 3'h1 >= adcpm_pkg::PULSE_NAP)
                pwr_next = adcpm_pkg::ADCPM_NAP;
        end
        unique case (seq_reg)
            ADCPM_IDLE: begin
                // a strobe rise starts conversion; power-down pulses also land here
                if (strb_rise && pwr_reg == adcpm_pkg::ADCPM_ACTIVE) begin
                    sar_next = 12'h800;
                    bit_next = 4'(adcpm_pkg::RES_BITS - 1);
                    bip_next = s_vss[1];
                    seq_next = ADCPM_CONVERSION_STROBE;
                end
            end
            ADCPM_CONVERSION_STROBE: begin
                // strobe ignored here: no restart mid conversion
                if (!comp_high) sar_next[bit_reg] = 1'b0;
                if (bit_reg != 4'h0) sar_next[bit_reg - 4'h1] = 1'b1;
                if (bit_reg == 4'h0) begin
                    // unipolar is straight binary, bipolar flips the msb
                    shreg_next = {settled_reg & ~s_vref[1],
                                  sar_next[11] ^ bip_reg, sar_next[10:0]};
                    seq_next   = ADCPM_SHIFT;
                    bit_next   = 4'(adcpm_pkg::WORD_BITS);
                end else begin
                    bit_next = bit_reg - 4'h1;
                end
            end
            ADCPM_SHIFT: begin
                if (sclk_rise) begin
                    dout_next  = shreg_reg[12];
                    shreg_next = {shreg_reg[11:0], 1'b0};
                    bit_next   = bit_reg - 4'h1;
                    if (bit_reg == 4'h1) seq_next = ADCPM_IDLE;
                end
            end
            default: seq_next = ADCPM_IDLE;
        endcase
        // a power-down train drops the conversion that its first pulse started,
        // so the next strobe after wake-up finds the sequencer idle
        if (pwr_next != adcpm_pkg::ADCPM_ACTIVE) seq_next = ADCPM_IDLE;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclk_d_reg  <= 1'b0;
            strb_d_reg  <= 1'b0;
            pwr_reg     <= adcpm_pkg::ADCPM_ACTIVE;
            pulses_reg  <= adcpm_pkg::PULSE_RST;
            settle_reg  <= 23'h0;
            settled_reg <= 1'b1;
            seq_reg     <= ADCPM_IDLE;
            bit_reg     <= 4'h0;
            sar_reg     <= 12'h0;
            shreg_reg   <= 13'h0;
            dout_reg    <= 1'b0;
            bip_reg     <= 1'b0;
        end else begin
            sclk_d_reg  <= s_sclk[1];
            strb_d_reg  <= s_strb[1];
            pwr_reg     <= pwr_next;
            pulses_reg  <= pulses_next;
            settle_reg  <= settle_next;
            settled_reg <= settled_next;
            seq_reg     <= seq_next;
            bit_reg     <= bit_next;
            sar_reg     <= sar_next;
            shreg_reg   <= shreg_next;
            dout_reg    <= dout_next;
            bip_reg     <= bip_next;
        end
    end

    assign link.dout    = dout_reg;
    assign ref_powered  = (pwr_reg != adcpm_pkg::ADCPM_SLEEP);
    assign core_powered = (pwr_reg == adcpm_pkg::ADCPM_ACTIVE);
    assign bipolar      = bip_reg;
    assign dac_trial    = sar_reg;
endmodule

// >>> rtl/adcpm_host.sv
// adcpm_host: host end that drives clock and strobe and reads the result
// assumes device on the same clk_sys; sclk is a divided output
`timescale 1ns/1ps
module adcpm_host (
    input  wire logic        clk_sys,    // system clock
    input  wire logic        rst,        // sync reset, active high
    adcpm_if.host            link,       // serial link
    input  wire logic        start,      // pulse: convert and read
    input  wire logic        nap_req,    // pulse: enter light power-down
    input  wire logic        sleep_req,  // pulse: enter deep sleep
    input  wire logic        wake_req,   // pulse: give one clock period
    output logic             busy,       // sequence running
    output logic             word_valid, // pulse: word captured
    output logic             settled,    // captured settled flag
    output logic [11:0]      result      // captured result
);
    typedef enum logic [1:0] {
        ADCPM_H_IDLE = 2'b00,
        ADCPM_H_STRB = 2'b01,
        ADCPM_H_CLK  = 2'b11
    } adcpm_hst_t;

    // two toggles make one strobe pulse or one clock period
    localparam logic [5:0] CONVERSION_STROBE_TOGGLES  = 6'h02;
    localparam logic [5:0] NAP_TOGGLES   = 6'(2 * adcpm_pkg::PULSE_NAP);
    localparam logic [5:0] SLEEP_TOGGLES = 6'(2 * adcpm_pkg::PULSE_SLEEP);
    localparam logic [5:0] WAKE_TOGGLES  = 6'h02;
    // a lead-in rise, whose stale capture falls out of the register, then one per bit
    localparam logic [5:0] FRAME_TOGGLES = 6'(2 * (adcpm_pkg::WORD_BITS + 1));

    adcpm_hst_t  st_reg, st_next;
    logic [3:0]  div_reg, div_next;
    logic [5:0]  cnt_reg, cnt_next;
    logic        sclk_reg, sclk_next;
    logic        strb_reg, strb_next;
    logic        conversion_strobe_reg, conversion_strobe_next;
    logic [12:0] cap_reg, cap_next;
    logic [11:0] res_reg, res_next;
    logic        set_reg, set_next;
    logic        val_reg, val_next;
    logic [1:0]  s_dout;
    logic        tick;

    always_ff @(posedge clk_sys) begin
        s_dout <= {s_dout[0], link.dout};
    end

    assign tick = (div_reg == 4'(adcpm_pkg::SCLK_DIV - 1));

    // ---------------------------------------------------------------
    // sequencer: strobe pulses with clock low, then clock bursts
    // ---------------------------------------------------------------
    always_comb begin
        st_next   = st_reg;
        div_next  = tick ? 4'h0 : div_reg + 4'h1;
        cnt_next  = cnt_reg;
        sclk_next = sclk_reg;
        strb_next = strb_reg;
        conversion_strobe_next = conversion_strobe_reg;
        cap_next  = cap_reg;
        res_next  = res_reg;
        set_next  = set_reg;
        val_next  = 1'b0;
        unique case (st_reg)
            ADCPM_H_IDLE: begin
                sclk_next = 1'b0;
                strb_next = 1'b0;
                conversion_strobe_next = start;
                if (start) begin
                    st_next  = ADCPM_H_STRB;
                    cnt_next = CONVERSION_STROBE_TOGGLES;
                end else if (nap_req) begin
                    st_next  = ADCPM_H_STRB;
                    cnt_next = NAP_TOGGLES;
                end else if (sleep_req) begin
                    st_next  = ADCPM_H_STRB;
                    cnt_next = SLEEP_TOGGLES;
                end else if (wake_req) begin
                    st_next  = ADCPM_H_CLK;
                    cnt_next = WAKE_TOGGLES;
                end
            end
            ADCPM_H_STRB: begin
                if (tick) begin
                    // clock stays low throughout the pulses
                    strb_next = ~strb_reg;
                    cnt_next  = cnt_reg - 6'h01;
                    if (cnt_reg == 6'h01) begin
                        // strobe high half plus clock low half outlast the conversion
                        st_next  = conversion_strobe_reg ? ADCPM_H_CLK : ADCPM_H_IDLE;
                        cnt_next = conversion_strobe_reg ? FRAME_TOGGLES : 6'h00;
                    end
                end
            end
            ADCPM_H_CLK: begin
                if (tick) begin
                    sclk_next = ~sclk_reg;
                    cnt_next  = cnt_reg - 6'h01;
                    if (!sclk_reg) begin
                        // taken as the clock rises, before the device moves the line
                        cap_next = {cap_reg[11:0], s_dout[1]};
                    end
                    if (cnt_reg == 6'h01) begin
                        st_next = ADCPM_H_IDLE;
                        if (conversion_strobe_reg) begin
                            res_next = cap_reg[11:0];
                            set_next = cap_reg[12];
                            val_next = 1'b1;
                        end
                    end
                end
            end
            default: st_next = ADCPM_H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg   <= ADCPM_H_IDLE;
            div_reg  <= 4'h0;
            cnt_reg  <= 6'h00;
            sclk_reg <= 1'b0;
            strb_reg <= 1'b0;
            conversion_strobe_reg <= 1'b0;
            cap_reg  <= 13'h0;
            res_reg  <= 12'h0;
            set_reg  <= 1'b0;
            val_reg  <= 1'b0;
        end else begin
            st_reg   <= st_next;
            div_reg  <= div_next;
            cnt_reg  <= cnt_next;
            sclk_reg <= sclk_next;
            strb_reg <= strb_next;
            conversion_strobe_reg <= conversion_strobe_next;
            cap_reg  <= cap_next;
            res_reg  <= res_next;
            set_reg  <= set_next;
            val_reg  <= val_next;
        end
    end

    assign link.sclk              = sclk_reg;
    assign link.conversion_strobe = strb_reg;
    assign busy       = (st_reg != ADCPM_H_IDLE);
    assign word_valid = val_reg;
    assign settled    = set_reg;
    assign result     = res_reg;
endmodule

// >>> verif/adcpm_props.sv
// adcpm_props: timing checks on the three-wire link between the two ends
// assumes host and device share clk_sys and the synchronous rst
`timescale 1ns/1ps
module adcpm_props (
    input  wire logic clk_sys,           // system clock
    input  wire logic rst,               // sync reset, active high
    input  wire logic sclk,              // serial clock from host
    input  wire logic conversion_strobe, // strobe from host
    input  wire logic dout               // serial result from device
);
    logic       sclk_prev_reg;
    logic [3:0] since_rise_reg;
    logic [3:0] since_rise_next;

    // ----------------------------------------
    // cycles since the last serial clock rise
    // ----------------------------------------
    always_comb begin
        since_rise_next = since_rise_reg;
        if (sclk && !sclk_prev_reg) begin
            since_rise_next = 4'h0;
        end else if (since_rise_reg != 4'hf) begin
            since_rise_next = since_rise_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclk_prev_reg  <= 1'b0;
            since_rise_reg <= 4'hf;
        end else begin
            sclk_prev_reg  <= sclk;
            since_rise_reg <= since_rise_next;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_strobe_width;
        $rose(conversion_strobe) |-> conversion_strobe [*8] ##1 !conversion_strobe;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe pulse not eight cycles wide");

    property p_strobe_gap;
        $fell(conversion_strobe) |-> !conversion_strobe [*8];
    endproperty
    a_strobe_gap: assert property (p_strobe_gap)
        else $error("strobe pulses too close together");

    property p_conversion_strobe_quiet;
        $rose(conversion_strobe) |-> !sclk [*8] ##1 !sclk [*8];
    endproperty
    a_conversion_strobe_quiet: assert property (p_conversion_strobe_quiet)
        else $error("serial clock ran during conversion");

    property p_sclk_low_strobe;
        conversion_strobe |-> !sclk;
    endproperty
    a_sclk_low_strobe: assert property (p_sclk_low_strobe)
        else $error("serial clock high while strobe high");

    property p_sclk_high_min;
        $rose(sclk) |-> sclk [*4];
    endproperty
    a_sclk_high_min: assert property (p_sclk_high_min)
        else $error("serial clock pulse too short to be seen");

    property p_dout_quiet_low;
        $fell(sclk) |=> $stable(dout) [*8];
    endproperty
    a_dout_quiet_low: assert property (p_dout_quiet_low)
        else $error("result line moved while serial clock low");

    property p_dout_on_rise;
        $changed(dout) |-> since_rise_reg <= 4'h8;
    endproperty
    a_dout_on_rise: assert property (p_dout_on_rise)
        else $error("result line moved away from a clock rise");

    property p_reset_idle;
        $fell(rst) |-> !sclk && !conversion_strobe && !dout;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("link not idle after reset");
endmodule

// >>> verif/test_adc_power_mode_and_output_format.sv
// test_adc_power_mode_and_output_format: host and device joined by the link
// assumes a comparator model that follows the device trial word directly
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module test_adc_power_mode_and_output_format;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0, nap_req = 1'b0, sleep_req = 1'b0, wake_req = 1'b0;
    logic        vss_below_gnd = 1'b0, vref_low = 1'b0;
    logic        comp_high, ref_powered, core_powered, bipolar;
    logic        busy, word_valid, settled;
    logic [11:0] dac_trial, result;
    logic [11:0] ain = 12'h000;
    logic [11:0] codes [4] = '{12'hbe6, 12'h000, 12'hfff, 12'h801};
    int          fail_count = 0;
    int          n_compared = 0;
    int          n_words = 0;

    // ideal input: the comparator says high while the trial is not above it
    assign comp_high = (dac_trial <= ain);

    adcpm_if link_if ();
    adcpm_device #(.SLEEP_WAKE_CYC(50)) adcpm_device_i (.clk_sys(clk_sys), .rst(rst),
        .link(link_if), .comp_high(comp_high), .vss_below_gnd(vss_below_gnd),
        .vref_low(vref_low), .ref_powered(ref_powered), .core_powered(core_powered),
        .bipolar(bipolar), .dac_trial(dac_trial));
    adcpm_host adcpm_host_i (.clk_sys(clk_sys), .rst(rst), .link(link_if), .start(start),
        .nap_req(nap_req), .sleep_req(sleep_req), .wake_req(wake_req), .busy(busy),
        .word_valid(word_valid), .settled(settled), .result(result));
    adcpm_props adcpm_props_i (.clk_sys(clk_sys), .rst(rst), .sclk(link_if.sclk),
        .conversion_strobe(link_if.conversion_strobe), .dout(link_if.dout));

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    // one captured word per conversion request, counted away from the launching edge
    always @(negedge clk_sys) begin
        if (word_valid === 1'b1) begin
            n_words++;
        end
    end

    task automatic report_and_stop();
        if (fail_count == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // one host request: {start, nap, sleep, wake}, then wait until idle
    // ----------------------------------------
    task automatic op(input logic [3:0] r);
        int n;
        n = 0;
        @(negedge clk_sys);
        {start, nap_req, sleep_req, wake_req} <= r;
        @(negedge clk_sys);
        {start, nap_req, sleep_req, wake_req} <= 4'h0;
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 5000) begin
            fail_count++;
            report_and_stop();
        end
        repeat (4) @(negedge clk_sys);
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(negedge clk_sys);
        rst <= 1'b0;
        @(negedge clk_sys);
        `CHK(core_powered, 1'b1)
        `CHK(ref_powered, 1'b1)
        for (int i = 0; i < 4; i++) begin
            ain = codes[i];
            op(4'h8);
            `CHK(result, codes[i])
            `CHK(settled, 1'b1)
            `CHK(bipolar, 1'b0)
        end
        // bipolar: the top code maps to the most positive two's complement value
        vss_below_gnd <= 1'b1;
        ain = 12'hfff;
        op(4'h8);
        `CHK(bipolar, 1'b1)
        `CHK(result, adcpm_pkg::BIP_MAX_CODE)
        ain = 12'h000;
        op(4'h8);
        `CHK(result, 12'h800)
        vss_below_gnd <= 1'b0;
        op(4'h4);
        `CHK(core_powered, 1'b0)
        `CHK(ref_powered, 1'b1)
        op(4'h1);
        repeat (adcpm_pkg::NAP_WAKE_CYC + 10) @(negedge clk_sys);
        `CHK(core_powered, 1'b1)
        ain = 12'h123;
        op(4'h8);
        `CHK(result, 12'h123)
        op(4'h2);
        `CHK(core_powered, 1'b0)
        `CHK(ref_powered, 1'b0)
        // converting at once after waking finds the reference still ramping
        op(4'h1);
        op(4'h8);
        `CHK(settled, 1'b0)
        op(4'h8);
        `CHK(settled, 1'b1)
        `CHK(ref_powered, 1'b1)
        `CHK(core_powered, 1'b1)
        vref_low <= 1'b1;
        op(4'h8);
        `CHK(settled, 1'b0)
        `CHK(result, 12'h123)
        `CHK(n_words, 32'h0000000a)
        report_and_stop();
    end
endmodule
